/* File: hw/edge_irq_pkg.sv */
// Package for the input edge interrupt filter.
// Assumes a 50 MHz system clock on mclk.
package edge_irq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned LOCKOUT_MS = 10;
	// Lockout length in cycles (10 ms at 50 MHz)
	localparam int unsigned LOCKOUT_CYCLES = (CLK_HZ / 1000) * LOCKOUT_MS;
	localparam int unsigned NUM_INPUTS = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0] SYNC_RESET = 3'h0;

	// ****************************************
	// Per-input channel states
	// ****************************************
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_LOCKED = 2'b01,
		CH_BUSY = 2'b10
	} chan_state_t;

	// Per-input status bundle
	typedef struct packed {
		logic event_pulse;
		logic preempt;
		logic busy;
	} chan_status_t;

endpackage : edge_irq_pkg

/* File: hw/edge_channel.sv */
// One input channel: synchroniser, edge detect, lockout and busy tracking.
// Assumes the pin is asynchronous to mclk and done comes from mclk logic.
`timescale 1ns/1ps
`default_nettype none
module edge_channel
	import edge_irq_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = LOCKOUT_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic pin,
	input wire logic done,
	output var chan_status_t status
);

	// ****************************************
	// Synchroniser and edge detect
	// ****************************************
	logic [2:0] sync_reg;
	logic level_reg;
	chan_state_t state_reg;
	logic [31:0] count_reg;
	logic preempt_reg;
	logic event_reg;
	logic busy_reg;

	// Change counts only once stages two and three agree
	wire agreed = (sync_reg[1] == sync_reg[2]);
	wire rise = agreed && sync_reg[2] && !level_reg;
	wire lock_end = (count_reg == 32'h0000_0001);
	wire accept = enable && rise && (state_reg == CH_IDLE);

	// Synchroniser chain
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync_reg <= SYNC_RESET;
			level_reg <= 1'b0;
		end else begin
			sync_reg <= {sync_reg[1:0], pin};
			if (agreed)
				level_reg <= sync_reg[2];
		end
	end

	// ****************************************
	// Lockout and handler tracking
	// ****************************************
	// Edges outside CH_IDLE are simply dropped, never queued
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= CH_IDLE;
			count_reg <= 32'h0000_0000;
			preempt_reg <= 1'b0;
			event_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			event_reg <= accept;
			unique case (state_reg)
				CH_IDLE: begin
					if (accept) begin
						state_reg <= CH_LOCKED;
						count_reg <= LOCK_CYCLES;
						preempt_reg <= 1'b1;
						busy_reg <= 1'b1;
					end
				end
				CH_LOCKED: begin
					// Done may come inside the window; remember it
					if (done)
						preempt_reg <= 1'b0;
					if (lock_end) begin
						count_reg <= 32'h0000_0000;
						state_reg <= (done || !preempt_reg) ? CH_IDLE : CH_BUSY;
						busy_reg <= !(done || !preempt_reg);
					end else begin
						count_reg <= count_reg - 32'h0000_0001;
					end
				end
				CH_BUSY: begin
					if (done) begin
						preempt_reg <= 1'b0;
						state_reg <= CH_IDLE;
						busy_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= CH_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	assign status.event_pulse = event_reg;
	assign status.preempt = preempt_reg;
	// Busy kept in its own flop so the top output is registered
	assign status.busy = busy_reg;

endmodule : edge_channel
`default_nettype wire

/* File: hw/input_edge_interrupt_filter.sv */
// Top of the fast input edge interrupt filter.
// Assumes pins are asynchronous; handler done pulses are on mclk.
`timescale 1ns/1ps
`default_nettype none
module input_edge_interrupt_filter
	import edge_irq_pkg::*;
#(
	parameter int unsigned N = NUM_INPUTS,
	parameter int unsigned LOCK_CYCLES = LOCKOUT_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [N-1:0] irq_mode_en,
	input wire logic [N-1:0] fast_in,
	input wire logic [N-1:0] handler_done,
	output logic [N-1:0] input_edge_event,
	output logic [N-1:0] preempt_req,
	output logic [N-1:0] handler_busy
);

	// ****************************************
	// One channel per input
	// ****************************************
	chan_status_t st [N];

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			// Separate channel so one edge wakes only its own handler
			edge_channel #(.LOCK_CYCLES(LOCK_CYCLES)) u_ch (
				.mclk(mclk),
				.resetn(resetn),
				.enable(irq_mode_en[g]),
				.pin(fast_in[g]),
				.done(handler_done[g]),
				.status(st[g])
			);
			assign input_edge_event[g] = st[g].event_pulse;
			assign preempt_req[g] = st[g].preempt;
			assign handler_busy[g] = st[g].busy;
		end
	endgenerate

endmodule : input_edge_interrupt_filter
`default_nettype wire

/* File: verif/edge_irq_props.sv */
// Port checker for the edge filter.
// Assumes one mclk domain, bound to the top.
`timescale 1ns/1ps
`default_nettype none
module edge_irq_props #(parameter int unsigned N = 4) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [N-1:0] irq_mode_en,
	input wire logic [N-1:0] handler_done,
	input wire logic [N-1:0] input_edge_event,
	input wire logic [N-1:0] preempt_req,
	input wire logic [N-1:0] handler_busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// An accepted event opens the window, so busy stands for a while
	sequence lock_run;
		handler_busy[0] [*8];
	endsequence
	chk_event_one_cycle: assert property ((input_edge_event & $past(input_edge_event)) == 0)
		else $error("event longer than one cycle");
	chk_event_when_on: assert property ((input_edge_event & ~$past(irq_mode_en)) == 0)
		else $error("event on a disabled input");
	chk_preempt_rise: assert property (
		input_edge_event == (preempt_req & ~$past(preempt_req)))
		else $error("preempt does not start with event");
	chk_lock_window: assert property (input_edge_event[0] |=> lock_run)
		else $error("lockout ended early");
	chk_drop_busy: assert property ((input_edge_event & $past(handler_busy)) == 0)
		else $error("event accepted while busy");
	chk_done_clears: assert property (|(preempt_req & handler_done)
		|=> (preempt_req & $past(preempt_req & handler_done)) == 0)
		else $error("preempt stays after done");
endmodule : edge_irq_props
bind input_edge_interrupt_filter edge_irq_props #(.N(N)) u_chk (.mclk, .resetn, .irq_mode_en,
	.handler_done, .input_edge_event, .preempt_req, .handler_busy);
`default_nettype wire

/* File: verif/edge_handler_model.sv */
// Handler tasks: run run_len cycles per request, then report once.
// Assumes preempt_req is registered on mclk.
`timescale 1ns/1ps
`default_nettype none
module edge_handler_model #(parameter int unsigned N = 4) (
	input wire logic mclk,
	input wire logic [7:0] run_len,
	input wire logic [N-1:0] preempt_req,
	output var logic [N-1:0] handler_done
);
	int cnt [N];
	// One-cycle completion pulse; the count runs past run_len so no repeat
	always @(posedge mclk) begin
		for (int i = 0; i < N; i++) begin
			cnt[i] <= preempt_req[i] ? cnt[i] + 1 : 0;
			handler_done[i] <= preempt_req[i] && cnt[i] == run_len;
		end
	end
endmodule : edge_handler_model
`default_nettype wire

/* File: verif/input_edge_interrupt_filter_tb.sv */
// Self-checking bench for the edge filter.
// Assumes a 20-cycle lockout for a short run.
`timescale 1ns/1ps
`default_nettype none
module input_edge_interrupt_filter_tb;
	logic mclk = 0, resetn = 0;
	logic [3:0] irq_mode_en = 4'hF, fast_in = 4'h0, handler_done, input_edge_event, preempt_req;
	logic [3:0] handler_busy;
	logic [7:0] run_len = 8'h03;
	int n_errors = 0, checks = 0, cyc = 0;
	input_edge_interrupt_filter #(.N(4), .LOCK_CYCLES(20)) i_dut (.mclk, .resetn, .irq_mode_en,
		.fast_in, .handler_done, .input_edge_event, .preempt_req, .handler_busy);
	edge_handler_model #(.N(4)) i_hnd (.mclk, .run_len, .preempt_req, .handler_done);
	initial forever #10 mclk = ~mclk;
	// Hang guard, far above the longest sequence
	always @(posedge mclk) if (++cyc == 3000) begin
		n_errors++;
		summarize();
	end
	task automatic chk(input string name, input logic [3:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Pin high four cycles so sync stages agree, gathering events over all 8 cycles from the pin rise
	task automatic edge_on(input int i, input logic [3:0] exp);
		logic [3:0] seen;
		seen = 4'h0;
		fast_in[i] = 1'b1;
		for (int j = 0; j < 8; j++) begin
			@(negedge mclk);
			seen |= input_edge_event;
			if (j == 3)
				fast_in[i] = 1'b0;
		end
		chk("event", seen, exp);
	endtask : edge_on
	task automatic t_lockout();
		edge_on(1, 4'h2);
		edge_on(1, 4'h0);
		repeat (30) @(negedge mclk);
		edge_on(1, 4'h2);
	endtask : t_lockout
	task automatic t_reentry();
		run_len = 8'h50;
		repeat (30) @(negedge mclk);
		edge_on(0, 4'h1);
		repeat (30) @(negedge mclk);
		edge_on(0, 4'h0);
		chk("busy", handler_busy, 4'h1);
		chk("preempt", preempt_req, 4'h1);
		repeat (90) @(negedge mclk);
		chk("busy", handler_busy, 4'h0);
		chk("preempt", preempt_req, 4'h0);
		edge_on(0, 4'h1);
	endtask : t_reentry
	task automatic t_disabled();
		irq_mode_en = 4'h7;
		edge_on(3, 4'h0);
		irq_mode_en = 4'hF;
	endtask : t_disabled
	task automatic summarize();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
		@(negedge mclk);
		t_lockout();
		t_reentry();
		t_disabled();
		summarize();
	end
endmodule : input_edge_interrupt_filter_tb
`default_nettype wire
